// *** sixteen_bit_timer_pkg.sv ***
// ****************************************************************
// shared constants of the sixteen bit timer
// ****************************************************************
package sixteen_bit_timer_pkg;

	// io space decode of the timer mode register
	localparam int IO_ADDR_WIDTH = 6;
	localparam logic [5:0] MODE_OFFSET = 6'h06;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// field positions inside timer_mode_select
	localparam int SRC_HI = 7;
	localparam int SRC_LO = 5;
	localparam int DIV_HI = 4;
	localparam int DIV_LO = 3;
	localparam int BIT_HI = 2;
	localparam int BIT_LO = 0;

	// clock source codes
	localparam logic [2:0] SRC_STOP = 3'h0;
	localparam logic [2:0] SRC_SYSTEM = 3'h1;
	localparam logic [2:0] SRC_RSVD_A = 3'h2;
	localparam logic [2:0] SRC_PIN_FOUR = 3'h3;
	localparam logic [2:0] SRC_FAST_OSC = 3'h4;
	localparam logic [2:0] SRC_RSVD_B = 3'h5;
	localparam logic [2:0] SRC_SLOW_OSC = 3'h6;
	localparam logic [2:0] SRC_PIN_ZERO = 3'h7;

	// prescaler codes
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_4 = 2'h1;
	localparam logic [1:0] DIV_16 = 2'h2;
	localparam logic [1:0] DIV_64 = 2'h3;

	// lowest counter bit that can be watched
	localparam int WATCH_BASE = 8;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [5:0] PRESCALE_RESET = 6'h00;

endpackage

// *** timer_prescaler.sv ***
`timescale 1ns/1ps
// ****************************************************************
// prescaler: passes one of every 1, 4, 16 or 64 input ticks
// ****************************************************************
module timer_prescaler
#(
	parameter int PRESCALE_WIDTH = 6
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// tick in and out
	input wire logic tickIn,
	input wire logic [1:0] divSelect,
	output logic tickOut
);

	typedef struct packed
	{
		logic [PRESCALE_WIDTH-1:0] phase;
	} prescale_state_type;

	prescale_state_type s;
	prescale_state_type next_s;
	logic phaseFull;

	// the phase counter runs freely, so a ratio change takes effect
	// at the next matching phase without a restart
	always_comb
	begin
		next_s = s;
		if (tickIn)
			next_s.phase = s.phase + 1'b1;
		unique case (divSelect)
			sixteen_bit_timer_pkg::DIV_1: phaseFull = 1'b1;
			sixteen_bit_timer_pkg::DIV_4: phaseFull = &s.phase[1:0];
			sixteen_bit_timer_pkg::DIV_16: phaseFull = &s.phase[3:0];
			sixteen_bit_timer_pkg::DIV_64: phaseFull = &s.phase[5:0];
		endcase
		tickOut = tickIn & phaseFull;
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			s <= '{phase: sixteen_bit_timer_pkg::PRESCALE_RESET};
		else
			s <= next_s;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	a_div_one_pass: assert property (
		divSelect == sixteen_bit_timer_pkg::DIV_1 |-> tickOut == tickIn)
		else $error("divide by one must pass every tick");
	a_no_tick_out: assert property (
		tickOut |-> tickIn)
		else $error("prescaler ticked with no input tick");
	// after a divide by four tick the next three cycles stay quiet
	a_div_four_gap: assert property (
		tickOut && divSelect == sixteen_bit_timer_pkg::DIV_4
		##1 (divSelect == sixteen_bit_timer_pkg::DIV_4)[*3]
		|-> !tickOut && !$past(tickOut) && !$past(tickOut, 2))
		else $error("divide by four ticked too often");

endmodule

// *** sixteen_bit_timer.sv ***
`timescale 1ns/1ps
// Overview of operation
// - sixteen bit counter clocked from one of five selectable sources.
// - mode bits 7..5 pick source; code zero stops counting.
// - prescaler divides selected clock by 1, 4, 16 or 64.
// - counter only counts up, one step per prescaled tick.
// - store instruction loads the counter from data memory.
// - read instruction copies the current count to data memory.
// - mode bits 2..0 pick watched counter bit 8 to 15.
// - edge select input picks rising or falling watched-bit edge.
// - watched-bit edge sets the timer request flag.
// - watching bit n gives one request per 2^(n+1) ticks.
// - hardware sets the request flag; software clears it.
// - power-save stops system or disabled-oscillator sources; else wakes.
module sixteen_bit_timer
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// io space register port
	input wire logic [5:0] ioAddr,
	input wire logic ioWrite,
	input wire logic [7:0] ioWriteData,
	input wire logic ioRead,
	output logic [7:0] ioReadData,
	// count load and store instructions
	input wire logic store_count_instruction,
	input wire logic [15:0] storeData,
	input wire logic read_count_instruction,
	output logic [15:0] countData,
	// external clock sources, asynchronous
	input wire logic port_a_pin_zero,
	input wire logic port_a_pin_four,
	input wire logic fast_internal_oscillator,
	input wire logic slow_internal_oscillator,
	// system state
	input wire logic powerSave,
	input wire logic fastOscEnable,
	input wire logic slowOscEnable,
	input wire logic edgeFalling,
	// request flag
	input wire logic requestClear,
	output logic timerRequest,
	output logic wakeRequest
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed
	{
		logic [7:0] mode;
		logic [15:0] count;
		logic [15:0] readBack;
		logic [7:0] ioData;
		logic request;
		logic wake;
		logic [3:0] syncA;
		logic [3:0] syncB;
		logic [3:0] last;
	} timer_state_type;

	timer_state_type s;
	timer_state_type next_s;

	logic [2:0] source;
	logic [1:0] divide;
	logic [2:0] watchSel;
	logic [3:0] edges;
	logic sourceTick;
	logic gated;
	logic countTick;
	logic [15:0] nextCount;
	logic oldBit;
	logic newBit;
	logic eventHit;

	assign source = s.mode[sixteen_bit_timer_pkg::SRC_HI:
		sixteen_bit_timer_pkg::SRC_LO];
	assign divide = s.mode[sixteen_bit_timer_pkg::DIV_HI:
		sixteen_bit_timer_pkg::DIV_LO];
	assign watchSel = s.mode[sixteen_bit_timer_pkg::BIT_HI:
		sixteen_bit_timer_pkg::BIT_LO];

	// ************************************************************
	// source selection
	// ************************************************************
	// rising edges of the synchronised pins and oscillators; only the
	// second stage is looked at, the first stage is metastability room
	assign edges = s.syncB & ~s.last;

	// a slow input clock must stay under half the system clock rate,
	// else edges are missed: that is the price of one clock domain
	always_comb
	begin
		unique case (source)
			sixteen_bit_timer_pkg::SRC_STOP: sourceTick = 1'b0;
			sixteen_bit_timer_pkg::SRC_SYSTEM: sourceTick = 1'b1;
			sixteen_bit_timer_pkg::SRC_PIN_FOUR: sourceTick = edges[1];
			sixteen_bit_timer_pkg::SRC_FAST_OSC: sourceTick = edges[2];
			sixteen_bit_timer_pkg::SRC_SLOW_OSC: sourceTick = edges[3];
			sixteen_bit_timer_pkg::SRC_PIN_ZERO: sourceTick = edges[0];
			default: sourceTick = 1'b0; // reserved codes do not count
		endcase
	end

	// power save halts the system clock source and dead oscillators
	always_comb
	begin
		gated = 1'b0;
		if (powerSave)
		begin
			if (source == sixteen_bit_timer_pkg::SRC_SYSTEM)
				gated = 1'b1;
			if (source == sixteen_bit_timer_pkg::SRC_FAST_OSC && !fastOscEnable)
				gated = 1'b1;
			if (source == sixteen_bit_timer_pkg::SRC_SLOW_OSC && !slowOscEnable)
				gated = 1'b1;
		end
	end

	timer_prescaler #(
		.PRESCALE_WIDTH(6)
	) prescaler (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tickIn(sourceTick & ~gated),
		.divSelect(divide),
		.tickOut(countTick)
	);

	// ************************************************************
	// counter and request event
	// ************************************************************
	// the sum drops its carry on purpose: maximum wraps to zero
	assign nextCount = s.count + 16'h0001;
	assign oldBit = s.count[sixteen_bit_timer_pkg::WATCH_BASE +
		int'(watchSel)];
	assign newBit = nextCount[sixteen_bit_timer_pkg::WATCH_BASE +
		int'(watchSel)];
	// a load never raises a request, only a counting step does
	assign eventHit = countTick && !store_count_instruction &&
		(edgeFalling ? (oldBit && !newBit) : (!oldBit && newBit));

	// next state
	always_comb
	begin
		next_s = s;
		next_s.syncA = {slow_internal_oscillator, fast_internal_oscillator,
			port_a_pin_four, port_a_pin_zero};
		next_s.syncB = s.syncA;
		next_s.last = s.syncB;
		// register write and registered readback
		if (ioWrite && ioAddr == sixteen_bit_timer_pkg::MODE_OFFSET)
			next_s.mode = ioWriteData;
		if (ioRead)
			next_s.ioData = (ioAddr == sixteen_bit_timer_pkg::MODE_OFFSET) ?
				s.mode : 8'h00;
		// a store in the same cycle as a tick wins over the tick
		if (store_count_instruction)
			next_s.count = storeData;
		else if (countTick)
			next_s.count = nextCount;
		if (read_count_instruction)
			next_s.readBack = s.count;
		// set beats clear so an event in the clear cycle is kept
		if (requestClear)
			next_s.request = 1'b0;
		if (eventHit)
			next_s.request = 1'b1;
		next_s.wake = eventHit && powerSave &&
			source != sixteen_bit_timer_pkg::SRC_SYSTEM;
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s.mode <= sixteen_bit_timer_pkg::MODE_RESET;
			s.count <= sixteen_bit_timer_pkg::COUNT_RESET;
			s.readBack <= sixteen_bit_timer_pkg::COUNT_RESET;
			s.ioData <= 8'h00;
			s.request <= 1'b0;
			s.wake <= 1'b0;
			s.syncA <= 4'h0;
			s.syncB <= 4'h0;
			s.last <= 4'h0;
		end
		else
			s <= next_s;
	end

	// outputs straight from flip-flops
	assign ioReadData = s.ioData;
	assign countData = s.readBack;
	assign timerRequest = s.request;
	assign wakeRequest = s.wake;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	a_stop_holds_count: assert property (
		source == sixteen_bit_timer_pkg::SRC_STOP && !store_count_instruction
		|=> s.count == $past(s.count))
		else $error("stopped timer changed its count");
	// reserved source codes must behave like the stop code
	a_reserved_holds: assert property (
		(source == sixteen_bit_timer_pkg::SRC_RSVD_A ||
		source == sixteen_bit_timer_pkg::SRC_RSVD_B) &&
		!store_count_instruction |=> $stable(s.count))
		else $error("reserved source code changed the count");
	a_system_counts: assert property (
		source == sixteen_bit_timer_pkg::SRC_SYSTEM &&
		divide == sixteen_bit_timer_pkg::DIV_1 && !powerSave &&
		!store_count_instruction
		|=> s.count == $past(s.count) + 16'h0001)
		else $error("system clock source did not count every cycle");
	// a synchronised pin edge shows in the count one cycle later
	a_pin_edge_counts: assert property (
		source == sixteen_bit_timer_pkg::SRC_PIN_ZERO &&
		divide == sixteen_bit_timer_pkg::DIV_1 && edges[0] &&
		!store_count_instruction
		|=> s.count == $past(s.count) + 16'h0001)
		else $error("pin source edge was not counted");
	a_up_one_step: assert property (
		countTick && !store_count_instruction
		|=> s.count == $past(s.count) + 16'h0001)
		else $error("count did not step up by one");
	a_store_loads: assert property (
		store_count_instruction |=> s.count == $past(storeData))
		else $error("store did not load the counter");
	// a load cannot itself raise a request
	a_load_no_request: assert property (
		store_count_instruction && !timerRequest |=> !timerRequest)
		else $error("count load raised a request");
	a_read_copies: assert property (
		read_count_instruction |=> countData == $past(s.count))
		else $error("read did not return the count");
	// the captured count stands until the next read instruction
	a_read_holds: assert property (
		!read_count_instruction |=> $stable(countData))
		else $error("captured count changed without a read");
	a_wrap_zero: assert property (
		countTick && !store_count_instruction && s.count == 16'hffff
		|=> s.count == 16'h0000 ##1
		(s.count <= 16'h0001 || $past(store_count_instruction)))
		else $error("counter did not wrap to zero");
	a_edge_direction: assert property (
		eventHit |-> newBit == !edgeFalling && oldBit == edgeFalling)
		else $error("request raised on the wrong edge");
	a_event_sets_flag: assert property (
		eventHit |=> timerRequest)
		else $error("event did not set the request flag");
	a_flag_sticky: assert property (
		timerRequest && !requestClear |=> timerRequest)
		else $error("request flag dropped without a clear");
	a_clear_drops: assert property (
		timerRequest && requestClear && !eventHit |=> !timerRequest)
		else $error("clear did not drop the request flag");
	a_bit8_period: assert property (
		watchSel == 3'h0 && eventHit |-> s.count[8:0] == 9'h0ff ||
		s.count[8:0] == 9'h1ff)
		else $error("bit eight request at the wrong count");
	a_psave_gates: assert property (
		powerSave && source == sixteen_bit_timer_pkg::SRC_SYSTEM &&
		!store_count_instruction |=> $stable(s.count))
		else $error("system clock source counted in power save");
	// a dead oscillator cannot tick while the system sleeps
	a_psave_osc_gates: assert property (
		powerSave && !store_count_instruction &&
		((source == sixteen_bit_timer_pkg::SRC_FAST_OSC &&
		!fastOscEnable) ||
		(source == sixteen_bit_timer_pkg::SRC_SLOW_OSC &&
		!slowOscEnable))
		|=> $stable(s.count))
		else $error("disabled oscillator source counted in power save");
	// a wake pulse only comes with a request raised in power save
	a_wake_in_save: assert property (
		wakeRequest |-> timerRequest && $past(powerSave) &&
		$past(source) != sixteen_bit_timer_pkg::SRC_SYSTEM)
		else $error("wake pulse outside power save");
	a_wake_single: assert property (
		wakeRequest |=> !wakeRequest)
		else $error("wake pulse lasted more than one cycle");
	a_mode_writes: assert property (
		ioWrite && ioAddr == sixteen_bit_timer_pkg::MODE_OFFSET
		|=> s.mode == $past(ioWriteData))
		else $error("mode register write lost");

	c_request_set: cover property (eventHit ##1 timerRequest);
	c_wrap: cover property (countTick && s.count == 16'hffff);
	c_set_and_clear: cover property (eventHit && requestClear);
	c_wake: cover property (wakeRequest);
	c_div_sixty_four: cover property (
		divide == sixteen_bit_timer_pkg::DIV_64 && countTick);

endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the sixteen bit timer
// ****************************************************************
module testbench;
	logic sys_clk, rst_b, ioWrite, ioRead, powerSave, edgeFalling;
	logic store_count_instruction, read_count_instruction, requestClear;
	logic timerRequest, wakeRequest;
	logic [5:0] ioAddr;
	logic [7:0] ioWriteData, ioReadData, rd8;
	logic [15:0] storeData, countData, rd16;
	logic [3:0] pins;
	logic [1:0] oscOn;
	int n_errors, n_checks, wakeCount, waited;
	logic [2:0] srcCode [4] = '{3'h7, 3'h3, 3'h4, 3'h6};
	logic [2:0] idleCode [3] = '{3'h0, 3'h2, 3'h5};

	sixteen_bit_timer DUT
	(
		.sys_clk(sys_clk), .rst_b(rst_b), .ioAddr(ioAddr),
		.ioWrite(ioWrite), .ioWriteData(ioWriteData), .ioRead(ioRead),
		.ioReadData(ioReadData), .storeData(storeData),
		.store_count_instruction(store_count_instruction),
		.read_count_instruction(read_count_instruction),
		.countData(countData), .port_a_pin_zero(pins[0]),
		.port_a_pin_four(pins[1]), .fast_internal_oscillator(pins[2]),
		.slow_internal_oscillator(pins[3]), .powerSave(powerSave),
		.fastOscEnable(oscOn[0]), .slowOscEnable(oscOn[1]),
		.edgeFalling(edgeFalling), .requestClear(requestClear),
		.timerRequest(timerRequest), .wakeRequest(wakeRequest)
	);

	// ****************************************************************
	// clock, wake pulse counter and helpers
	// ****************************************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// the wake output is a one-cycle pulse, so it is tallied, not polled
	always @(posedge sys_clk)
		if (wakeRequest === 1'b1) wakeCount++;

	task check(input string what, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task test_done;
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one register access, then an idle cycle so strobes never rejoin
	task io_rw(input logic wr, input logic [5:0] a, input logic [7:0] d);
		ioAddr = a;
		ioWriteData = d;
		ioWrite = wr;
		ioRead = !wr;
		@(negedge sys_clk);
		ioWrite = 1'b0;
		ioRead = 1'b0;
		rd8 = ioReadData;
		@(negedge sys_clk);
	endtask

	// store (st=1) or read (st=0) count instruction
	task instr(input logic st, input logic [15:0] v);
		storeData = v;
		store_count_instruction = st;
		read_count_instruction = !st;
		@(negedge sys_clk);
		store_count_instruction = 1'b0;
		read_count_instruction = 1'b0;
		rd16 = countData;
		@(negedge sys_clk);
	endtask

	task clear_req;
		requestClear = 1'b1;
		@(negedge sys_clk);
		requestClear = 1'b0;
		@(negedge sys_clk);
	endtask

	// bounded wait for the request flag; a timeout ends the run
	task wait_req(input int limit);
		waited = 0;
		while (timerRequest !== 1'b1 && waited < limit)
		begin
			@(negedge sys_clk);
			waited++;
		end
		check("timerRequest", timerRequest, 16'h1);
		if (timerRequest !== 1'b1) test_done;
	endtask

	// slow pin pulses, well under half the system clock rate
	task pulse(input logic [3:0] which, input int k);
		repeat (k)
		begin
			pins = which;
			repeat (4) @(negedge sys_clk);
			pins = 4'h0;
			repeat (4) @(negedge sys_clk);
		end
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{rst_b, ioWrite, ioRead, powerSave, edgeFalling} = 5'h00;
		{store_count_instruction, read_count_instruction} = 2'h0;
		{requestClear, ioAddr, ioWriteData, storeData} = 31'h0;
		pins = 4'h0;
		oscOn = 2'h3;
		{n_errors, n_checks, wakeCount} = '0;
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		instr(1'b0, 16'h0000);
		check("count after reset", rd16, 16'h0000);
		io_rw(1'b0, sixteen_bit_timer_pkg::MODE_OFFSET, 8'h00);
		check("mode reset", rd8, 16'h0000);
		io_rw(1'b1, 6'h07, 8'hff);
		io_rw(1'b0, 6'h07, 8'h00);
		check("unmapped read", rd8, 16'h0000);
		io_rw(1'b1, sixteen_bit_timer_pkg::MODE_OFFSET, 8'ha5);
		io_rw(1'b0, sixteen_bit_timer_pkg::MODE_OFFSET, 8'h00);
		check("mode readback", rd8, 16'h00a5);
		// stop and reserved codes must hold the stored count
		for (int i = 0; i < 3; i++)
		begin
			io_rw(1'b1, 6'h06, {idleCode[i], 5'h00});
			instr(1'b1, 16'h1234);
			pulse(4'hf, 3);
			instr(1'b0, 16'h0000);
			check("held count", rd16, 16'h1234);
		end
		// each pin or oscillator source counts its own rising edges
		for (int i = 0; i < 4; i++)
		begin
			io_rw(1'b1, 6'h06, {srcCode[i], 5'h00});
			instr(1'b1, 16'h0000);
			pulse(4'h1 << i, 5);
			repeat (6) @(negedge sys_clk);
			instr(1'b0, 16'h0000);
			check("source count", rd16, 16'h0005);
		end
		// every watched bit on both edges; the last case wraps past 0xffff
		for (int e = 0; e < 2; e++)
			for (int n = 0; n < 8; n++)
			begin
				edgeFalling = e[0];
				io_rw(1'b1, 6'h06, {3'h1, 2'h0, n[2:0]});
				instr(1'b1, 16'((17'h1 << (n + 8 + e)) - 17'h4));
				clear_req;
				check("early request", timerRequest, 16'h0);
				wait_req(4);
			end
		edgeFalling = 1'b0;
		io_rw(1'b1, 6'h06, 8'h27);
		instr(1'b1, 16'hfffc);
		clear_req;
		repeat (6) @(negedge sys_clk);
		check("wrong edge", timerRequest, 16'h0);
		// request period on bit 8 for every prescaler code
		for (int d = 0; d < 4; d++)
		begin
			io_rw(1'b1, 6'h06, {3'h1, d[1:0], 3'h0});
			clear_req;
			wait_req(33000);
			clear_req;
			wait_req((512 << (2 * d)) + 8);
			check("period", 16'(waited + 2), 16'(512 << (2 * d)));
			repeat (8) @(negedge sys_clk);
			check("sticky", timerRequest, 16'h1);
		end
		// power save: system source and a disabled oscillator both stop
		powerSave = 1'b1;
		io_rw(1'b1, 6'h06, 8'h20);
		instr(1'b1, 16'h0040);
		repeat (10) @(negedge sys_clk);
		instr(1'b0, 16'h0000);
		check("save system", rd16, 16'h0040);
		oscOn = 2'h2;
		io_rw(1'b1, 6'h06, 8'h80);
		instr(1'b1, 16'h0040);
		pulse(4'h4, 3);
		instr(1'b0, 16'h0000);
		check("save disabled", rd16, 16'h0040);
		oscOn = 2'h1;
		io_rw(1'b1, 6'h06, 8'hc0);
		instr(1'b1, 16'h0040);
		pulse(4'h8, 3);
		instr(1'b0, 16'h0000);
		check("save slow disabled", rd16, 16'h0040);
		oscOn = 2'h3;
		io_rw(1'b1, 6'h06, 8'hc0);
		instr(1'b1, 16'h00fd);
		clear_req;
		wakeCount = 0;
		pulse(4'h8, 3);
		repeat (4) @(negedge sys_clk);
		check("wake pulses", 16'(wakeCount), 16'h1);
		check("save request", timerRequest, 16'h1);
		// a second reset in mid-run must clear the flag, mode and count
		rst_b = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("request after reset", timerRequest, 16'h0);
		rst_b = 1'b1;
		io_rw(1'b0, sixteen_bit_timer_pkg::MODE_OFFSET, 8'h00);
		check("mode after reset", rd8, 16'h0000);
		instr(1'b0, 16'h0000);
		check("stopped after reset", rd16, 16'h0000);
		test_done;
	end
endmodule
